// ==== lamp_pkg.sv ====
package lamp_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned CLK_FREQ_HZ     = 250_000_000;
  localparam int unsigned TICK_PERIOD_US  = 1000;
  localparam int unsigned TICK_CYCLES     = CLK_FREQ_HZ / 1_000_000 * TICK_PERIOD_US;
  localparam int unsigned BLINK_HALF_MS   = 200;
  localparam int unsigned FLASH_ON_MS     = 200;
  localparam int unsigned FLASH_OFF_MS    = 1000;
  localparam int unsigned FLICKER_HALF_MS = 50;
  localparam int unsigned DOUBLE_GAP_MS   = 200;
  localparam int unsigned DOUBLE_FRAME_MS = 2 * FLASH_ON_MS + DOUBLE_GAP_MS + FLASH_OFF_MS;
  localparam int unsigned FRAME_MS        = 2000;
  localparam int unsigned TICK_COUNT_W    = 18;
  localparam int unsigned FRAME_W         = 11;

  // ****************************************
  // Network states and fault classes
  // ****************************************
  typedef enum logic [1:0] {
    NET_INIT, NET_PREOP, NET_SAFEOP, NET_OP
  } net_state_type;

  typedef enum logic [2:0] {
    FAULT_NONE, FAULT_CONFIG, FAULT_SYNC, FAULT_APP_WDT, FAULT_BOOT, FAULT_IF_WDT
  } net_fault_type;

endpackage : lamp_pkg

// ==== lamp_timebase.sv ====
`timescale 1ns/1ns
module lamp_timebase
  import lamp_pkg::*;
(
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rst_n,
  // Pattern outputs and 1 ms tick
  output logic      blink,
  output logic      single_flash,
  output logic      double_flash,
  output logic      flicker,
  output logic      ms_tick
);

  logic [TICK_COUNT_W-1:0] pre_q, pre_d;
  logic [FRAME_W-1:0]      ms_q, ms_d;
  logic [FRAME_W-1:0]      dms_q, dms_d;
  logic                    blink_q, blink_d, sflash_q, sflash_d;
  logic                    dflash_q, dflash_d, flick_q, flick_d;

  always_comb begin
    ms_tick = (pre_q == TICK_COUNT_W'(TICK_CYCLES - 1));
    pre_d   = ms_tick ? '0 : pre_q + 1'b1;
    ms_d    = ms_q;
    dms_d   = dms_q;
    if (ms_tick) begin
      ms_d  = (ms_q == FRAME_W'(FRAME_MS - 1)) ? '0 : ms_q + 1'b1;
      dms_d = (dms_q == FRAME_W'(DOUBLE_FRAME_MS - 1)) ? '0 : dms_q + 1'b1;
    end
    // Blink: 200 ms halves give 2.5 Hz; flicker: 50 ms halves give 10 Hz
    blink_d  = ((ms_q / FRAME_W'(BLINK_HALF_MS)) % 2) == 0;
    flick_d  = ((ms_q / FRAME_W'(FLICKER_HALF_MS)) % 2) == 0;
    // Single flash: 200 ms on, taken modulo 1.2 s of the 1.6 s double counter, so the off time alternates 1 s and 200 ms
    sflash_d = (dms_q % FRAME_W'(FLASH_ON_MS + FLASH_OFF_MS)) < FRAME_W'(FLASH_ON_MS);
    dflash_d = (dms_q < FRAME_W'(FLASH_ON_MS)) ||
               ((dms_q >= FRAME_W'(FLASH_ON_MS + DOUBLE_GAP_MS)) &&
                (dms_q < FRAME_W'(2 * FLASH_ON_MS + DOUBLE_GAP_MS)));
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_q    <= '0;
      ms_q     <= '0;
      dms_q    <= '0;
      blink_q  <= 1'b0;
      sflash_q <= 1'b0;
      dflash_q <= 1'b0;
      flick_q  <= 1'b0;
    end else begin
      pre_q    <= pre_d;
      ms_q     <= ms_d;
      dms_q    <= dms_d;
      blink_q  <= blink_d;
      sflash_q <= sflash_d;
      dflash_q <= dflash_d;
      flick_q  <= flick_d;
    end
  end

  assign blink        = blink_q;
  assign single_flash = sflash_q;
  assign double_flash = dflash_q;
  assign flicker      = flick_q;

endmodule : lamp_timebase

// ==== status_indicator_logic.sv ====
// Notes on behaviour
// - Green run lamp on in normal operation; off on no power, hardware or host fault.
// - Unit error lamp on while any unit error is active, otherwise off.
// - Host error lamp on while the host controller reports an error.
// - Network state lamp: off init, blink preop, single flash safeop, on op.
// - Fault lamp: off, blink, single, double, flicker or steady per fault class.
// - Link lamp off without link, steady with link, flicker with traffic.
`timescale 1ns/1ns
module status_indicator_logic
  import lamp_pkg::*;
(
  // Clock and reset
  input  wire logic          core_clk,
  input  wire logic          rst_n,
  // Unit conditions
  input  wire logic          power_good,
  input  wire logic          hw_fault,
  input  wire logic          host_flagged_fault,
  input  wire logic          unit_error,
  input  wire logic          host_error,
  // Network conditions
  input  wire lamp_pkg::net_state_type net_state,
  input  wire lamp_pkg::net_fault_type net_fault,
  input  wire logic          link_up,
  input  wire logic          link_traffic,
  // Lamp drives
  output logic               run_indicator,
  output logic               unit_error_indicator,
  output logic               host_error_indicator,
  output logic               network_state_indicator,
  output logic               network_fault_indicator,
  output logic               link_activity_indicator
);

  import lamp_pkg::*;

  // ****************************************
  // Input synchronisers
  // ****************************************
  // Conditions may come from other clock domains, so all pass two stages
  localparam int unsigned IN_W = 10;
  logic [IN_W-1:0] raw_in, sync1_q, sync2_q;

  assign raw_in = {power_good, hw_fault, host_flagged_fault, unit_error, host_error,
                   net_state, link_up, link_traffic, 1'b0};

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= raw_in;
      sync2_q <= sync1_q;
    end
  end

  logic [2:0] fault_s1_q, fault_s2_q;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      fault_s1_q <= '0;
      fault_s2_q <= '0;
    end else begin
      fault_s1_q <= net_fault;
      fault_s2_q <= fault_s1_q;
    end
  end

  logic          s_power, s_hw, s_hflag, s_uerr, s_herr, s_link, s_traffic;
  net_state_type s_state;
  net_fault_type s_fault;
  assign s_power   = sync2_q[9];
  assign s_hw      = sync2_q[8];
  assign s_hflag   = sync2_q[7];
  assign s_uerr    = sync2_q[6];
  assign s_herr    = sync2_q[5];
  assign s_state   = net_state_type'(sync2_q[4:3]);
  assign s_link    = sync2_q[2];
  assign s_traffic = sync2_q[1];
  assign s_fault   = net_fault_type'(fault_s2_q);

  // ****************************************
  // Shared time base
  // ****************************************
  logic pat_blink, pat_single, pat_double, pat_flicker, ms_tick;

  lamp_timebase u_timebase (
    .core_clk     (core_clk),
    .rst_n        (rst_n),
    .blink        (pat_blink),
    .single_flash (pat_single),
    .double_flash (pat_double),
    .flicker      (pat_flicker),
    .ms_tick      (ms_tick)
  );

  // ****************************************
  // Lamp selection
  // ****************************************
  logic run_d, uerr_d, herr_d, nst_d, nflt_d, lnk_d;
  logic run_q, uerr_q, herr_q, nst_q, nflt_q, lnk_q;

  always_comb begin
    run_d  = s_power && !s_hw && !s_hflag;
    uerr_d = s_uerr;
    herr_d = s_herr;
    case (s_state)
      NET_INIT:   nst_d = 1'b0;
      NET_PREOP:  nst_d = pat_blink;
      NET_SAFEOP: nst_d = pat_single;
      NET_OP:     nst_d = 1'b1;
      default:    nst_d = 1'b0;
    endcase
    case (s_fault)
      FAULT_NONE:    nflt_d = 1'b0;
      FAULT_CONFIG:  nflt_d = pat_blink;
      FAULT_SYNC:    nflt_d = pat_single;
      FAULT_APP_WDT: nflt_d = pat_double;
      FAULT_BOOT:    nflt_d = pat_flicker;
      FAULT_IF_WDT:  nflt_d = 1'b1;
      default:       nflt_d = 1'b0;
    endcase
    // Traffic without a link cannot be real, so the link qualifies it
    if (!s_link) begin
      lnk_d = 1'b0;
    end else if (s_traffic) begin
      lnk_d = pat_flicker;
    end else begin
      lnk_d = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      run_q  <= 1'b0;
      uerr_q <= 1'b0;
      herr_q <= 1'b0;
      nst_q  <= 1'b0;
      nflt_q <= 1'b0;
      lnk_q  <= 1'b0;
    end else begin
      run_q  <= run_d;
      uerr_q <= uerr_d;
      herr_q <= herr_d;
      nst_q  <= nst_d;
      nflt_q <= nflt_d;
      lnk_q  <= lnk_d;
    end
  end

  assign run_indicator           = run_q;
  assign unit_error_indicator    = uerr_q;
  assign host_error_indicator    = herr_q;
  assign network_state_indicator = nst_q;
  assign network_fault_indicator = nflt_q;
  assign link_activity_indicator = lnk_q;

  // ****************************************
  // Checks
  // ****************************************
  chk_run_lamp_off: assert property (@(posedge core_clk) disable iff (!rst_n)
    (!power_good || hw_fault || host_flagged_fault) [*4] |-> !run_indicator)
    else $error("run lamp lit during a fault");
  chk_unit_err_follow: assert property (@(posedge core_clk) disable iff (!rst_n)
    unit_error [*5] |-> unit_error_indicator)
    else $error("unit error lamp not lit");
  chk_host_err_follow: assert property (@(posedge core_clk) disable iff (!rst_n)
    !host_error [*4] |-> !host_error_indicator)
    else $error("host error lamp lit without error");
  chk_net_op_steady: assert property (@(posedge core_clk) disable iff (!rst_n)
    (net_state == NET_OP) [*5] |-> network_state_indicator)
    else $error("network state lamp not steady in op");
  chk_net_init_off: assert property (@(posedge core_clk) disable iff (!rst_n)
    (net_state == NET_INIT) [*4] |-> !network_state_indicator)
    else $error("network state lamp lit in init");
  chk_fault_wdt_on: assert property (@(posedge core_clk) disable iff (!rst_n)
    (net_fault == FAULT_IF_WDT) [*5] |-> network_fault_indicator)
    else $error("fault lamp not steady on interface timeout");
  chk_fault_none_off: assert property (@(posedge core_clk) disable iff (!rst_n)
    (net_fault == FAULT_NONE) [*4] |-> !network_fault_indicator)
    else $error("fault lamp lit with no fault");
  chk_link_states: assert property (@(posedge core_clk) disable iff (!rst_n)
    (link_up && !link_traffic) [*5] |-> link_activity_indicator)
    else $error("link lamp not steady on idle link");
  chk_tick_spacing: assert property (@(posedge core_clk) disable iff (!rst_n)
    ms_tick |=> !ms_tick [*8])
    else $error("time base ticks too close");

endmodule : status_indicator_logic

// ==== status_indicator_logic_tb.sv ====
`timescale 1ns/1ns
module status_indicator_logic_tb;
  import lamp_pkg::*;

  // ****************************************
  // Stimulus and design
  // ****************************************
  logic          core_clk;
  logic          rst_n;
  logic          power_good;
  logic          hw_fault;
  logic          host_flagged_fault;
  logic          unit_error;
  logic          host_error;
  net_state_type net_state;
  net_fault_type net_fault;
  logic          link_up;
  logic          link_traffic;
  logic          run_l, unit_l, host_l, state_l, fault_l, link_l;
  int            n_fail;
  int            compares;
  int            cycles;
  logic [2:0]    fcode [8];
  logic          fexp  [8];

  status_indicator_logic status_indicator_logic_inst (
    .core_clk(core_clk), .rst_n(rst_n), .power_good(power_good), .hw_fault(hw_fault),
    .host_flagged_fault(host_flagged_fault), .unit_error(unit_error),
    .host_error(host_error), .net_state(net_state), .net_fault(net_fault),
    .link_up(link_up), .link_traffic(link_traffic), .run_indicator(run_l),
    .unit_error_indicator(unit_l), .host_error_indicator(host_l),
    .network_state_indicator(state_l), .network_fault_indicator(fault_l),
    .link_activity_indicator(link_l));

  always #2 core_clk = ~core_clk;

  // ****************************************
  // Tasks
  // ****************************************
  task automatic check_bit(input string what, input logic exp, input logic got);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask : check_bit

  // Steady and pattern lamps alike need three edges; wait well past that
  task automatic settle();
    repeat (6) @(posedge core_clk);
    #1;
  endtask : settle

  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : summarize

  // Blinking patterns span tens of millions of cycles, so patterns are judged only in their first lit phase
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      $display("CHECK FAILED run length expected end seen hang");
      summarize();
    end
  end

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    core_clk = 1'b0; rst_n = 1'b0; n_fail = 0; compares = 0; cycles = 0;
    power_good = 1'b1; hw_fault = 1'b0; host_flagged_fault = 1'b0;
    unit_error = 1'b1; host_error = 1'b1; net_state = NET_OP;
    net_fault = FAULT_IF_WDT; link_up = 1'b1; link_traffic = 1'b0;
    // Every pattern opens in its lit phase after reset, which lasts far beyond this run
    fcode = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7};
    fexp  = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
    repeat (4) @(posedge core_clk);
    #1;
    check_bit("run in reset", 1'b0, run_l);
    check_bit("unit in reset", 1'b0, unit_l);
    check_bit("host in reset", 1'b0, host_l);
    check_bit("state in reset", 1'b0, state_l);
    check_bit("fault in reset", 1'b0, fault_l);
    check_bit("link in reset", 1'b0, link_l);
    @(posedge core_clk);
    rst_n <= 1'b1;
    settle();
    check_bit("run on", 1'b1, run_l);
    check_bit("unit on", 1'b1, unit_l);
    check_bit("host on", 1'b1, host_l);
    check_bit("state op", 1'b1, state_l);
    check_bit("fault pdi wdt", 1'b1, fault_l);
    check_bit("link steady", 1'b1, link_l);
    $display("Test reset done");
    for (int i = 0; i < 8; i++) begin
      @(posedge core_clk);
      power_good <= i[0]; hw_fault <= i[1]; host_flagged_fault <= i[2];
      settle();
      check_bit("run lamp", i[0] & ~i[1] & ~i[2], run_l);
    end
    $display("Test run lamp done");
    for (int i = 0; i < 4; i++) begin
      @(posedge core_clk);
      unit_error <= i[0]; host_error <= i[1];
      settle();
      check_bit("unit lamp", i[0], unit_l);
      check_bit("host lamp", i[1], host_l);
    end
    $display("Test error lamps done");
    @(posedge core_clk);
    net_state <= NET_INIT;
    settle();
    check_bit("state init", 1'b0, state_l);
    @(posedge core_clk);
    net_state <= NET_PREOP;
    settle();
    check_bit("state preop lit", 1'b1, state_l);
    @(posedge core_clk);
    net_state <= NET_SAFEOP;
    settle();
    check_bit("state safeop lit", 1'b1, state_l);
    @(posedge core_clk);
    net_state <= NET_OP;
    settle();
    check_bit("state op again", 1'b1, state_l);
    $display("Test state lamp done");
    for (int i = 0; i < 8; i++) begin
      @(posedge core_clk);
      net_fault <= net_fault_type'(fcode[i]);
      settle();
      check_bit("fault lamp", fexp[i], fault_l);
    end
    $display("Test fault lamp done");
    for (int i = 0; i < 4; i++) begin
      @(posedge core_clk);
      link_up <= i[1]; link_traffic <= i[0];
      settle();
      check_bit("link lamp", i[1], link_l);
    end
    $display("Test link lamp done");
    summarize();
  end

endmodule : status_indicator_logic_tb
